// ===== sshc_map.vh
// Purpose: constants for the stepper stop/home command decoder
// Assumes: 8-bit commands, msb first on the serial link
// Notes:   opcodes are exact bytes except the leave-switch group
`ifndef SSHC_MAP_VH
`define SSHC_MAP_VH
`define SSHC_OP_LEAVE_MASK   8'hF6
`define SSHC_OP_LEAVE        8'h92
`define SSHC_OP_LEAVE_SAVE   3
`define SSHC_OP_LEAVE_DIR    0
`define SSHC_OP_GO_ZERO      8'h70
`define SSHC_OP_GO_SAVED     8'h78
`define SSHC_OP_CLEAR_POS    8'hD8
`define SSHC_OP_FULL_RESET   8'hC0
`define SSHC_OP_RAMP_STOP    8'hB0
`define SSHC_OP_INST_STOP    8'hB8
`define SSHC_OP_RAMP_FLOAT   8'hA0
`define SSHC_OP_INST_FLOAT   8'hA8
`define SSHC_OP_READ_STATE   8'hD0
`define SSHC_OP_STOP_BIT     4
`define SSHC_OP_INSTANT_BIT  3
`define SSHC_LEAVE_SPEED_SPS 8'h05
`define SSHC_STAT_BRIDGES_OFF 0
`define SSHC_STAT_BUSY       1
`define SSHC_STAT_REJECTED   7
`define SSHC_STAT_WARN_MASK  16'hFF00
`define SSHC_MOT_IDLE        3'h0
`define SSHC_MOT_LEAVE       3'h1
`define SSHC_MOT_GOTO        3'h2
`define SSHC_MOT_RAMP        3'h3
`endif

// ===== sshc_decoder.v
// Purpose: serial command decoder for the stop, home and status commands
// Assumes: CLK_SYS 25 MHz; link pins are asynchronous and pass two flops
// Notes:   the motion engine is outside; this block issues its requests
`timescale 1ns/10ps
`include "sshc_map.vh"
module sshc_decoder
#(
   parameter POS_W    = 22,
   parameter SPEED_W  = 20,
   parameter CLK_HZ   = 25000000
)
(
   input  wire               CLK_SYS,
   input  wire               RST,
   input  wire               LINK_SCK,
   input  wire               LINK_CS_N,
   input  wire               LINK_MOSI,
   output reg                LINK_MISO,
   input  wire               LIMIT_SWITCH_INPUT,
   input  wire [SPEED_W-1:0] MIN_SPEED,
   input  wire               LOW_SPEED_OPT,
   input  wire [SPEED_W-1:0] DECEL_RATE,
   input  wire               MOTOR_STOPPED,
   input  wire               TARGET_REACHED,
   input  wire [15:0]        WARN_FLAGS,
   output reg                BUSY_N,
   output reg  [POS_W-1:0]   ABSOLUTE_POSITION,
   output reg  [POS_W-1:0]   SAVED_POSITION,
   output reg                BRIDGES_OFF_FLAG,
   output reg                COMMAND_REJECTED_FLAG,
   output reg                ERROR_CLEAR,
   output reg                MOVE_RUN,
   output reg                MOVE_DIR,
   output reg  [SPEED_W-1:0] MOVE_SPEED,
   output reg  [SPEED_W-1:0] MOVE_DECEL,
   output reg                MOVE_GOTO,
   output reg  [POS_W-1:0]   GOTO_TARGET,
   output reg                INSTANT_STOP,
   output reg                RAMP_STOP,
   output reg                FULL_RESET_PULSE,
   output wire [15:0]        STATUS_WORD
);
   // 5 step/s floor in the engine speed unit, supplied by the engine's scaling
   localparam [SPEED_W-1:0] LEAVE_SPEED = {{(SPEED_W-8){1'b0}}, `SSHC_LEAVE_SPEED_SPS};

   // two-flop synchronisers; stage one feeds stage two only
   reg [2:0] sync1;
   reg [2:0] sync2;
   reg       sck_prev;
   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         // idle levels (select high, clock high) so no false edge follows reset
         sync1    <= 3'h3;
         sync2    <= 3'h3;
         sck_prev <= 1'b1;
      end
      else
      begin
         sync1    <= {LIMIT_SWITCH_INPUT, LINK_CS_N, LINK_SCK};
         sync2    <= sync1;
         sck_prev <= sync2[0];
      end
   end
   reg mosi1;
   reg mosi2;
   always @(posedge CLK_SYS)
   begin
      if (RST)
      begin
         mosi1 <= 1'b0;
         mosi2 <= 1'b0;
      end
      else
      begin
         mosi1 <= LINK_MOSI;
         mosi2 <= mosi1;
      end
   end
   wire sck_s  = sync2[0];
   wire cs_n_s = sync2[1];
   wire switch_s = sync2[2];
   wire sck_rise = sck_s & ~sck_prev;
   wire sck_fall = ~sck_s & sck_prev;

   // status word: bridges-off, busy, reject, plus external warnings
   // warnings belong to the engine; ERROR_CLEAR asks it to drop them
   reg  rejected_sticky;
   assign STATUS_WORD = (WARN_FLAGS & `SSHC_STAT_WARN_MASK)
                      | ({15'h0000, BRIDGES_OFF_FLAG} << `SSHC_STAT_BRIDGES_OFF)
                      | ({15'h0000, BUSY_N} << `SSHC_STAT_BUSY)
                      | ({15'h0000, rejected_sticky} << `SSHC_STAT_REJECTED);

   // byte shifter: sample on rising sck, shift out on falling, msb first
   reg [7:0]  rx_shift;
   reg [2:0]  bit_cnt;
   reg [15:0] reply;
   reg [1:0]  reply_left;
   reg        byte_done;
   reg [7:0]  rx_byte;
   reg        in_frame;
   always @(posedge CLK_SYS)
   begin
      byte_done <= 1'b0;
      if (RST)
      begin
         rx_shift  <= 8'h00;
         bit_cnt   <= 3'h0;
         rx_byte   <= 8'h00;
         LINK_MISO <= 1'b0;
         in_frame  <= 1'b0;
      end
      else if (cs_n_s)
      begin
         bit_cnt  <= 3'h0;
         in_frame <= 1'b0;
      end
      else
      begin
         if (!in_frame)
         begin
            in_frame  <= 1'b1;
            LINK_MISO <= (reply_left == 2'd2) ? reply[15] : reply[7];
         end
         if (sck_rise)
         begin
            rx_shift <= {rx_shift[6:0], mosi2};
            bit_cnt  <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
               rx_byte   <= {rx_shift[6:0], mosi2};
               byte_done <= 1'b1;
            end
         end
         else if (sck_fall)
         begin
            LINK_MISO <= (reply_left == 2'd2) ? reply[15 - {1'b0, bit_cnt}] : reply[7 - {1'b0, bit_cnt}];
         end
      end
   end

   // command execution and motion supervision
   reg [2:0] mode;
   reg       leave_save;
   reg       float_after;
   always @(posedge CLK_SYS)
   begin
      INSTANT_STOP     <= 1'b0;
      RAMP_STOP        <= 1'b0;
      MOVE_GOTO        <= 1'b0;
      ERROR_CLEAR      <= 1'b0;
      FULL_RESET_PULSE <= 1'b0;
      COMMAND_REJECTED_FLAG <= 1'b0;
      if (RST || (byte_done && reply_left == 2'd0 && rx_byte == `SSHC_OP_FULL_RESET))
      begin
         mode              <= `SSHC_MOT_IDLE;
         BUSY_N            <= 1'b1;
         ABSOLUTE_POSITION <= {POS_W{1'b0}};
         SAVED_POSITION    <= {POS_W{1'b0}};
         BRIDGES_OFF_FLAG  <= 1'b1;
         rejected_sticky   <= 1'b0;
         MOVE_RUN          <= 1'b0;
         MOVE_DIR          <= 1'b0;
         MOVE_SPEED        <= {SPEED_W{1'b0}};
         MOVE_DECEL        <= {SPEED_W{1'b0}};
         GOTO_TARGET       <= {POS_W{1'b0}};
         reply             <= 16'h0000;
         reply_left        <= 2'd0;
         leave_save        <= 1'b0;
         float_after       <= 1'b0;
         FULL_RESET_PULSE  <= ~RST;
      end
      else
      begin
         // motion completion; a command decoded later in this cycle overrides it
         case (mode)
            `SSHC_MOT_LEAVE:
            begin
               if (switch_s && MOVE_RUN)
               begin
                  if (leave_save)
                     SAVED_POSITION <= ABSOLUTE_POSITION;
                  else
                     ABSOLUTE_POSITION <= {POS_W{1'b0}};
                  MOVE_RUN     <= 1'b0;
                  INSTANT_STOP <= 1'b1;
               end
               else if (!MOVE_RUN && MOTOR_STOPPED)
               begin
                  mode   <= `SSHC_MOT_IDLE;
                  BUSY_N <= 1'b1;
               end
            end
            `SSHC_MOT_GOTO:
            begin
               if (TARGET_REACHED)
               begin
                  mode   <= `SSHC_MOT_IDLE;
                  BUSY_N <= 1'b1;
               end
            end
            `SSHC_MOT_RAMP:
            begin
               if (MOTOR_STOPPED)
               begin
                  mode   <= `SSHC_MOT_IDLE;
                  BUSY_N <= 1'b1;
                  if (float_after)
                     BRIDGES_OFF_FLAG <= 1'b1;
               end
            end
            default:
               mode <= `SSHC_MOT_IDLE;
         endcase

         // reply bytes consumed one per frame
         // bytes arriving while the reply drains are dropped, so the host may send filler
         if (byte_done && reply_left != 2'd0)
         begin
            reply_left <= reply_left - 2'd1;
         end
         else if (byte_done)
         begin
            if ((rx_byte & `SSHC_OP_LEAVE_MASK) == `SSHC_OP_LEAVE)
            begin
               mode      <= `SSHC_MOT_LEAVE;
               BUSY_N    <= 1'b0;
               leave_save <= rx_byte[`SSHC_OP_LEAVE_SAVE];
               MOVE_DIR  <= rx_byte[`SSHC_OP_LEAVE_DIR];
               MOVE_RUN  <= 1'b1;
               MOVE_SPEED <= (MIN_SPEED < LEAVE_SPEED || LOW_SPEED_OPT) ? LEAVE_SPEED : MIN_SPEED;
            end
            else if (rx_byte == `SSHC_OP_GO_ZERO || rx_byte == `SSHC_OP_GO_SAVED)
            begin
               if (!BUSY_N)
               begin
                  rejected_sticky       <= 1'b1;
                  COMMAND_REJECTED_FLAG <= 1'b1;
               end
               else
               begin
                  mode        <= `SSHC_MOT_GOTO;
                  BUSY_N      <= 1'b0;
                  MOVE_GOTO   <= 1'b1;
                  GOTO_TARGET <= (rx_byte == `SSHC_OP_GO_ZERO) ? {POS_W{1'b0}} : SAVED_POSITION;
               end
            end
            else if (rx_byte == `SSHC_OP_CLEAR_POS)
               ABSOLUTE_POSITION <= {POS_W{1'b0}};
            else if (rx_byte == `SSHC_OP_RAMP_STOP || rx_byte == `SSHC_OP_INST_STOP
                     || rx_byte == `SSHC_OP_RAMP_FLOAT || rx_byte == `SSHC_OP_INST_FLOAT)
            begin
               MOVE_RUN    <= 1'b0;
               MOVE_DECEL  <= DECEL_RATE;
               // stop bit set marks the two stops, clear the two floats
               float_after <= ~rx_byte[`SSHC_OP_STOP_BIT];
               // instant bit picks the infinite-deceleration flavour of either pair
               if (rx_byte[`SSHC_OP_INSTANT_BIT])
                  INSTANT_STOP <= 1'b1;
               else
                  RAMP_STOP <= 1'b1;
               // stop commands leave floating with no motion; instant float floats now
               if (rx_byte[`SSHC_OP_STOP_BIT])
                  BRIDGES_OFF_FLAG <= 1'b0;
               else if (rx_byte[`SSHC_OP_INSTANT_BIT] || MOTOR_STOPPED)
                  BRIDGES_OFF_FLAG <= 1'b1;
               mode   <= `SSHC_MOT_RAMP;
               BUSY_N <= 1'b0;
            end
            else if (rx_byte == `SSHC_OP_READ_STATE)
            begin
               reply           <= STATUS_WORD;
               reply_left      <= 2'd2;
               rejected_sticky <= 1'b0;
               ERROR_CLEAR     <= 1'b1;
            end
         end
      end
   end
endmodule

// ===== sshc_props.sv
// Purpose: timing checker for the stop/home command decoder ports
// Assumes: one clock domain, RST synchronous and active high
// Notes:   bounds follow the hand-over latencies of one cycle (busy) or two cycles (status, reset)
`timescale 1ns/10ps
module sshc_props
#(
   parameter POS_W = 22
)
(
   input wire             CLK_SYS,
   input wire             RST,
   input wire             BUSY_N,
   input wire             MOTOR_STOPPED,
   input wire             TARGET_REACHED,
   input wire [POS_W-1:0] ABSOLUTE_POSITION,
   input wire             BRIDGES_OFF_FLAG,
   input wire             COMMAND_REJECTED_FLAG,
   input wire             ERROR_CLEAR,
   input wire             MOVE_GOTO,
   input wire             INSTANT_STOP,
   input wire             RAMP_STOP,
   input wire             FULL_RESET_PULSE,
   input wire [15:0]      STATUS_WORD
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // a stop on a moving motor is one request, then busy
   sequence s_stop;
      (RAMP_STOP || INSTANT_STOP) && !MOTOR_STOPPED;
   endsequence
   AST_STOP_BUSY: assert property (s_stop |-> ##[0:1] !BUSY_N)
      else $error("busy not low after stop");
   AST_STOP_PULSE: assert property (s_stop |=> !(RAMP_STOP || INSTANT_STOP))
      else $error("stop request longer than one cycle");
   AST_BUSY_FREE: assert property ($rose(BUSY_N) |-> $past(MOTOR_STOPPED) || $past(TARGET_REACHED)
      || FULL_RESET_PULSE)
      else $error("busy released while moving");
   AST_GOTO_BUSY: assert property (MOVE_GOTO |-> ##[0:1] !BUSY_N)
      else $error("busy not low after goto");
   AST_REJ_STICKY: assert property (COMMAND_REJECTED_FLAG |-> ##[0:2] STATUS_WORD[7])
      else $error("reject not kept in status");
   AST_REJ_NOGO: assert property (COMMAND_REJECTED_FLAG |-> !MOVE_GOTO ##1 !MOVE_GOTO)
      else $error("rejected command moved");
   AST_ERR_CLR: assert property (ERROR_CLEAR |-> ##[0:2] !STATUS_WORD[7] && $stable(BRIDGES_OFF_FLAG))
      else $error("read state clear wrong");
   AST_STATUS_MAP: assert property (STATUS_WORD[1:0] == {BUSY_N, BRIDGES_OFF_FLAG})
      else $error("status low bits wrong");
   AST_FULL_RST: assert property (FULL_RESET_PULSE |-> ##[0:2] BRIDGES_OFF_FLAG && BUSY_N
      && ABSOLUTE_POSITION == 0)
      else $error("full reset state wrong");
   AST_RST_VAL: assert property (disable iff (1'b0) RST |=> BUSY_N && BRIDGES_OFF_FLAG)
      else $error("reset state wrong");
endmodule
bind sshc_decoder sshc_props #(.POS_W(POS_W)) i_sshc_props
(
   .CLK_SYS(CLK_SYS), .RST(RST), .BUSY_N(BUSY_N), .MOTOR_STOPPED(MOTOR_STOPPED),
   .TARGET_REACHED(TARGET_REACHED), .ABSOLUTE_POSITION(ABSOLUTE_POSITION), .BRIDGES_OFF_FLAG(BRIDGES_OFF_FLAG),
   .COMMAND_REJECTED_FLAG(COMMAND_REJECTED_FLAG), .ERROR_CLEAR(ERROR_CLEAR), .MOVE_GOTO(MOVE_GOTO),
   .INSTANT_STOP(INSTANT_STOP), .RAMP_STOP(RAMP_STOP), .FULL_RESET_PULSE(FULL_RESET_PULSE), .STATUS_WORD(STATUS_WORD)
);

// ===== sshc_host.sv
// Purpose: host model driving the serial command link
// Assumes: 320 ns serial clock that idles high outside frames
// Notes:   reply bits are taken late in the high phase for margin
`timescale 1ns/10ps
module sshc_host
(
   output reg  sck = 1'b1,
   output reg  cs_n = 1'b1,
   output reg  mosi = 1'b0,
   input  wire miso
);
   // one byte per frame, msb first on both lines
   task xfer(input [7:0] tx, output [7:0] rx);
      integer i;
      begin
         #5; // step off the clock edge so the pins never race the sampling flops
         cs_n = 1'b0;
         #160;
         for (i = 7; i >= 0; i = i - 1)
         begin
            sck = 1'b0;
            mosi = tx[i];
            #160;
            sck = 1'b1;
            #150;
            rx[i] = miso;
            #10;
         end
         #160;
         cs_n = 1'b1;
         mosi = ~mosi; // no stale bit once released
         #320;
      end
   endtask
endmodule

// ===== sshc_decoder_bench.sv
// Purpose: self-checking bench for the stop/home command decoder
// Assumes: the bench plays the motion engine, the host model the link
// Notes:   pulses are tallied since one cycle is easy to miss
`timescale 1ns/10ps
module sshc_decoder_bench;
   reg         clk = 1'b0, rst = 1'b1, lim = 1'b0, lso = 1'b0, ms = 1'b1, tr = 1'b0;
   reg  [19:0] mins = 20'h0_0000, drate = 20'h0_0000;
   reg  [15:0] warn = 16'h0000;
   reg  [7:0]  r1, r2;
   reg  [10:0] fl;
   wire        sck, cs_n, mosi, miso, busy_n, boff, rej, eclr, run, dir, mgo, istp, rstp, frp;
   wire [19:0] mspd, mdec;
   wire [21:0] apos, spos, gtgt;
   wire [15:0] stw;
   integer     seed = 32'hd416_a1cf, err_total = 0, comparisons = 0, k, ni;
   integer     n [0:5] = '{0, 0, 0, 0, 0, 0};
   localparam [65:0] FLT = {8'hA8, 3'b011, 8'hB8, 3'b100, 8'hA0, 3'b111, 8'hB0, 3'b100, 8'hA0, 3'b001,
      8'hB8, 3'b100};
   sshc_decoder #(.POS_W(22), .SPEED_W(20), .CLK_HZ(25000000)) i_sshc_decoder
   (
      .CLK_SYS(clk), .RST(rst), .LINK_SCK(sck), .LINK_CS_N(cs_n), .LINK_MOSI(mosi), .LINK_MISO(miso),
      .LIMIT_SWITCH_INPUT(lim), .MIN_SPEED(mins), .LOW_SPEED_OPT(lso), .DECEL_RATE(drate), .MOTOR_STOPPED(ms),
      .TARGET_REACHED(tr), .WARN_FLAGS(warn), .BUSY_N(busy_n), .ABSOLUTE_POSITION(apos), .SAVED_POSITION(spos),
      .BRIDGES_OFF_FLAG(boff), .COMMAND_REJECTED_FLAG(rej), .ERROR_CLEAR(eclr), .MOVE_RUN(run), .MOVE_DIR(dir),
      .MOVE_SPEED(mspd), .MOVE_DECEL(mdec), .MOVE_GOTO(mgo), .GOTO_TARGET(gtgt), .INSTANT_STOP(istp),
      .RAMP_STOP(rstp), .FULL_RESET_PULSE(frp), .STATUS_WORD(stw)
   );
   sshc_host i_sshc_host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   // clock and pulse tallies
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      n[0] <= n[0] + (rstp === 1'b1);
      n[1] <= n[1] + (istp === 1'b1);
      n[2] <= n[2] + (rej === 1'b1);
      n[3] <= n[3] + (mgo === 1'b1);
      n[4] <= n[4] + (eclr === 1'b1);
      n[5] <= n[5] + (frp === 1'b1);
   end
   function [19:0] leave_spd(input [19:0] m, input l);
      leave_spd = (m < 20'h0_0005 || l) ? 20'h0_0005 : m;
   endfunction
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp)
         begin
            err_total = err_total + 1;
            $display("mismatch %0s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task cmd(input [7:0] b);
      begin
         i_sshc_host.xfer(b, r1);
         repeat (4) @(posedge clk);
      end
   endtask
   // bounded wait for busy release
   task wbusy;
      integer j;
      begin
         for (j = 0; j < 40 && busy_n !== 1'b1; j = j + 1) @(posedge clk);
         @(posedge clk);
      end
   endtask
   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, err_total);
         if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // watchdog, well beyond the expected run
   initial
   begin
      #1000000;
      err_total = err_total + 1;
      summarize;
   end
   // main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      drate <= 20'($random(seed));
      warn <= 16'($random(seed));
      ms <= 1'b0;
      repeat (4) @(posedge clk);
      chk("bridges", boff, 1);
      chk("busy", busy_n, 1);
      cmd(8'hB0);
      chk("ramp", n[0], 1);
      chk("unfloat", boff, 0);
      chk("no run", run, 0);
      chk("decel", mdec, drate);
      chk("busy stop", busy_n, 0);
      cmd(8'h70);
      cmd(8'h78);
      chk("rejects", n[2], 2);
      chk("no goto", n[3], 0);
      chk("sticky", stw[7], 1);
      @(posedge clk) ms <= 1'b1;
      wbusy;
      chk("busy free", busy_n, 1);
      cmd(8'hD0);
      r1 = 8'($random(seed));
      i_sshc_host.xfer(r1, r1);
      r2 = 8'($random(seed));
      i_sshc_host.xfer(r2, r2);
      repeat (4) @(posedge clk);
      chk("status msb", r1, warn[15:8]);
      chk("status lsb", r2, 8'h82);
      chk("err clear", n[4], 1);
      chk("sticky gone", stw[7], 0);
      chk("bridges kept", boff, 0);
      // goto zero, then goto saved, each on a free device
      for (k = 0; k < 2; k = k + 1)
      begin
         wbusy;
         @(posedge clk) ms <= 1'b0;
         cmd(k ? 8'h78 : 8'h70);
         chk("goto", n[3], k + 1);
         chk("target", gtgt, 0);
         chk("busy go", busy_n, 0);
         @(posedge clk) {ms, tr} <= 2'b11;
         @(posedge clk) tr <= 1'b0;
         wbusy;
         chk("busy done", busy_n, 1);
      end
      // floats on a running and a standing motor, stops on a standing one
      for (k = 0; k < 6; k = k + 1)
      begin
         fl = FLT[(5 - k) * 11 +: 11];
         @(posedge clk) ms <= fl[2];
         cmd(fl[10:3]);
         chk("float now", boff, fl[1]);
         chk("busy float", busy_n, fl[2]);
         @(posedge clk) ms <= 1'b1;
         wbusy;
         chk("float later", boff, fl[0]);
      end
      // leave the switch for each action and direction
      for (k = 0; k < 4; k = k + 1)
      begin
         @(posedge clk) {mins, lso, ms, lim} <= {20'($random(seed)) & 20'h0_000F, 1'($random(seed)), 2'b00};
         cmd({4'h9, k[1], 2'b01, k[0]});
         chk("run", run, 1);
         chk("dir", dir, k[0]);
         chk("speed", mspd, leave_spd(mins, lso));
         chk("busy leave", busy_n, 0);
         ni = n[1];
         @(posedge clk) lim <= 1'b1;
         repeat (8) @(posedge clk);
         chk("hard stop", n[1] - ni, 1);
         chk("busy moving", busy_n, 0);
         @(posedge clk) ms <= 1'b1;
         wbusy;
         chk("busy end", busy_n, 1);
         chk("saved pos", spos, 22'h00_0000);
      end
      cmd(8'hD8);
      chk("position", apos, 0);
      cmd(8'hC0);
      chk("reset pulse", n[5], 1);
      chk("bridges pwr", boff, 1);
      summarize;
   end
endmodule
